// File: hw/supflt_detector.sv
// Notes on behaviour
// - Ten channels: one HV, four LV, five dual
// - Dual channel is detector or logic, never both
// - Per channel fault type: under, over, window
// - Thresholds are 8-bit codes on range span
// - Range selectable, limited by channel kind
// - Comparisons run every cycle when enabled
// - Hysteresis widens only the clearing threshold
// - Hysteresis is a 5-bit code, span/255 units
// - Glitch filter follows hysteresis as last stage
// - Filter timeout programmable 0 to 100 us
// - Pulses shorter than timeout are suppressed
// - Passed transitions delayed by the timeout
`timescale 1ns/100ps
module supflt_detector (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [79:0] level_code,  // Digitised rail levels, 8 bits per channel
  input  wire logic [4:0]  logic_in,    // Dual function inputs as logic levels
  output logic      [9:0]  fault_out,   // Filtered fault per detector channel
  output logic      [4:0]  logic_out,   // Filtered logic level per dual channel
  output logic             irq
);

  // -------------------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------------------

  // Merge write data under byte strobes
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : strobe_merge

  // Keep a control word legal for the channel kind
  function automatic logic [31:0] sanitize_ctl(input int unsigned ch, input logic [31:0] w);
    logic [31:0] res;
    logic [1:0]  rng;
    res = w & supflt_pkg::CTL_WMASK;
    rng = res[supflt_pkg::RANGE_LSB +: 2];
    if (ch == supflt_pkg::HV_CH) begin
      if (rng < supflt_pkg::RANGE_HIGH) rng = supflt_pkg::RANGE_HIGH;
    end else if (ch < supflt_pkg::FIRST_DUAL) begin
      if (rng == supflt_pkg::RANGE_TOP) rng = supflt_pkg::RANGE_HIGH;
    end else begin
      rng = supflt_pkg::RANGE_LOW;
    end
    res[supflt_pkg::RANGE_LSB +: 2] = rng;
    // Only dual channels may act as logic inputs
    if (ch < supflt_pkg::FIRST_DUAL) res[supflt_pkg::LSEL_BIT] = 1'b0;
    // Unused code 2 folds to window so every value has a meaning
    if (res[supflt_pkg::MODE_LSB +: 2] == 2'h2) begin
      res[supflt_pkg::MODE_LSB +: 2] = supflt_pkg::SUPFLT_WINDOW;
    end
    if (res[supflt_pkg::GLT_LSB +: 7] > supflt_pkg::GLITCH_MAX_US) begin
      res[supflt_pkg::GLT_LSB +: 7] = supflt_pkg::GLITCH_MAX_US;
    end
    return res;
  endfunction : sanitize_ctl

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  logic [31:0] thr_q [supflt_pkg::NUM_CH];  // Thresholds and hysteresis
  logic [31:0] thr_d [supflt_pkg::NUM_CH];
  logic [31:0] ctl_q [supflt_pkg::NUM_CH];  // Mode, range, enable, select, timeout
  logic [31:0] ctl_d [supflt_pkg::NUM_CH];
  logic [9:0]  mask_q, mask_d;              // Interrupt mask
  logic [9:0]  status_q, status_d;          // Sticky fault events
  logic [9:0]  uvf_q, uvf_d;                // Undervoltage comparator states
  logic [9:0]  ovf_q, ovf_d;                // Overvoltage comparator states
  logic [9:0]  raw;                         // Comparator result per channel
  logic [9:0]  filt_in;                     // Filter input per channel
  logic [9:0]  filt;                        // Filter output per channel
  logic [9:0]  fault_q, fault_d;
  logic [4:0]  lout_q, lout_d;
  logic        irq_q, irq_d;
  logic [6:0]  tdiv_q, tdiv_d;              // Timebase divider
  logic        tick_q, tick_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // -------------------------------------------------------------------------
  // Timebase: one microsecond enable for the filters
  // -------------------------------------------------------------------------
  always_comb begin
    tick_d = 1'b0;
    tdiv_d = tdiv_q + 7'h01;
    if (tdiv_q == 7'(supflt_pkg::TICK_CYCLES - 1)) begin
      tdiv_d = 7'h00;
      tick_d = 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Comparators with hysteresis
  // -------------------------------------------------------------------------
  // Evaluated every cycle, so a fault needs no software request
  always_comb begin
    for (int i = 0; i < supflt_pkg::NUM_CH; i++) begin
      logic [8:0] code;
      logic [8:0] uv_th;
      logic [8:0] ov_th;
      logic [8:0] hy;
      logic       en;
      logic       lsel;
      code  = {1'b0, level_code[i*8 +: 8]};
      uv_th = {1'b0, thr_q[i][supflt_pkg::UV_LSB +: 8]};
      ov_th = {1'b0, thr_q[i][supflt_pkg::OV_LSB +: 8]};
      hy    = {4'h0, thr_q[i][supflt_pkg::HYST_LSB +: supflt_pkg::HYST_W]};
      en    = ctl_q[i][supflt_pkg::EN_BIT];
      lsel  = ctl_q[i][supflt_pkg::LSEL_BIT];
      // Under: trips below threshold, clears only above threshold plus hysteresis
      if (uvf_q[i]) begin
        uvf_d[i] = !(code > uv_th + hy);
      end else begin
        uvf_d[i] = code < uv_th;
      end
      // Over: trips above threshold, clears only below threshold minus hysteresis
      if (ovf_q[i]) begin
        ovf_d[i] = !(code + hy < ov_th);
      end else begin
        ovf_d[i] = code > ov_th;
      end
      // Disabled or logic channels hold their comparators idle
      if (!en || lsel) begin
        uvf_d[i] = 1'b0;
        ovf_d[i] = 1'b0;
      end
      case (supflt_pkg::supflt_mode_t'(ctl_q[i][supflt_pkg::MODE_LSB +: 2]))
        supflt_pkg::SUPFLT_UNDER:  raw[i] = uvf_q[i];
        supflt_pkg::SUPFLT_OVER:   raw[i] = ovf_q[i];
        supflt_pkg::SUPFLT_WINDOW: raw[i] = uvf_q[i] | ovf_q[i];
        default:                   raw[i] = uvf_q[i] | ovf_q[i];
      endcase
      // Logic mode routes the pin, not the comparator, into the filter
      // Modulo keeps the pin index in range on the dedicated channels
      filt_in[i] = raw[i];
      if (i >= supflt_pkg::FIRST_DUAL && lsel && en) begin
        filt_in[i] = logic_in[(i - supflt_pkg::FIRST_DUAL) % supflt_pkg::NUM_DUAL];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Glitch filters, one per channel
  // -------------------------------------------------------------------------
  for (genvar g = 0; g < supflt_pkg::NUM_CH; g++) begin : g_filt
    supflt_glitch_filter u_filt (
      .clk     (pclk),
      .rst_n   (presetn),
      .tick    (tick_q),
      .timeout (ctl_q[g][supflt_pkg::GLT_LSB +: supflt_pkg::GLT_W]),
      .din     (filt_in[g]),
      .dout    (filt[g])
    );
  end

  // -------------------------------------------------------------------------
  // Outputs, events and interrupt
  // -------------------------------------------------------------------------
  logic        rd_hit;   // Completing read this cycle
  logic        wr_hit;   // Completing write this cycle
  logic [11:0] ch_off;
  logic [3:0]  ch_idx;
  logic        ch_sel;

  assign rd_hit = psel & penable & ~pready_q & ~pwrite;
  assign wr_hit = psel & penable & ~pready_q & pwrite;
  assign ch_off = paddr - supflt_pkg::OFS_CH_BASE;
  assign ch_idx = ch_off[6:3];
  assign ch_sel = (paddr >= supflt_pkg::OFS_CH_BASE) && (ch_idx < 4'(supflt_pkg::NUM_CH))
                  && (paddr[1:0] == 2'h0) && (ch_off[11:7] == 5'h00);

  // Logic channels never report as faults; detectors never as logic levels
  always_comb begin
    for (int i = 0; i < supflt_pkg::NUM_CH; i++) begin
      fault_d[i] = filt[i] & ctl_q[i][supflt_pkg::EN_BIT] & ~ctl_q[i][supflt_pkg::LSEL_BIT];
    end
    for (int j = 0; j < supflt_pkg::NUM_DUAL; j++) begin
      lout_d[j] = filt[supflt_pkg::FIRST_DUAL + j] &
                  ctl_q[supflt_pkg::FIRST_DUAL + j][supflt_pkg::LSEL_BIT] &
                  ctl_q[supflt_pkg::FIRST_DUAL + j][supflt_pkg::EN_BIT];
    end
    // A new fault wins over a status read in the same cycle
    status_d = status_q;
    if (rd_hit && paddr == supflt_pkg::OFS_STATUS) status_d = 10'h000;
    status_d = status_d | (fault_d & ~fault_q);
    irq_d    = |(status_d & mask_d);
  end

  // -------------------------------------------------------------------------
  // APB slave: one wait state, pslverr on unmapped or misaligned address
  // -------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < supflt_pkg::NUM_CH; i++) begin
      thr_d[i] = thr_q[i];
      ctl_d[i] = ctl_q[i];
    end
    mask_d    = mask_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = psel & penable & ~pready_q;
    if (wr_hit) begin
      if (paddr == supflt_pkg::OFS_MASK) begin
        mask_d = 10'(strobe_merge({22'h0, mask_q}, pwdata, pstrb));
      end else if (paddr == supflt_pkg::OFS_STATUS || paddr == supflt_pkg::OFS_LIVE ||
                   paddr == supflt_pkg::OFS_RAW) begin
        mask_d = mask_q;                                // Read-only, write ignored
      end else if (ch_sel) begin
        if (!paddr[2]) begin
          thr_d[ch_idx] = strobe_merge(thr_q[ch_idx], pwdata, pstrb)
                          & supflt_pkg::THR_WMASK;
        end else begin
          ctl_d[ch_idx] = sanitize_ctl(32'(ch_idx), strobe_merge(ctl_q[ch_idx], pwdata, pstrb));
        end
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (rd_hit) begin
      prdata_d = 32'h0000_0000;
      if (paddr == supflt_pkg::OFS_STATUS) begin
        prdata_d = {22'h0, status_q};
      end else if (paddr == supflt_pkg::OFS_MASK) begin
        prdata_d = {22'h0, mask_q};
      end else if (paddr == supflt_pkg::OFS_LIVE) begin
        prdata_d = {11'h0, lout_q, 6'h0, fault_q};
      end else if (paddr == supflt_pkg::OFS_RAW) begin
        prdata_d = {12'h0, 10'(raw), 10'(filt_in)};
      end else if (ch_sel) begin
        prdata_d = paddr[2] ? ctl_q[ch_idx] : thr_q[ch_idx];
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < supflt_pkg::NUM_CH; i++) begin
        thr_q[i] <= supflt_pkg::THR_RESET;
        ctl_q[i] <= supflt_pkg::CTL_RESET;
      end
      mask_q    <= 10'h000;
      status_q  <= 10'h000;
      uvf_q     <= 10'h000;
      ovf_q     <= 10'h000;
      fault_q   <= 10'h000;
      lout_q    <= 5'h00;
      irq_q     <= 1'b0;
      tdiv_q    <= 7'h00;
      tick_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      for (int i = 0; i < supflt_pkg::NUM_CH; i++) begin
        thr_q[i] <= thr_d[i];
        ctl_q[i] <= ctl_d[i];
      end
      mask_q    <= mask_d;
      status_q  <= status_d;
      uvf_q     <= uvf_d;
      ovf_q     <= ovf_d;
      fault_q   <= fault_d;
      lout_q    <= lout_d;
      irq_q     <= irq_d;
      tdiv_q    <= tdiv_d;
      tick_q    <= tick_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign fault_out = fault_q;
  assign logic_out = lout_q;
  assign irq       = irq_q;

endmodule : supflt_detector

// File: hw/supflt_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants for the supply fault detector
// ---------------------------------------------------------------------------
package supflt_pkg;

  // Channel plan: 0 high voltage, 1..4 low voltage, 5..9 dual function
  localparam int unsigned NUM_CH      = 10;
  localparam int unsigned NUM_DUAL    = 5;
  localparam int unsigned FIRST_DUAL  = 5;
  localparam int unsigned HV_CH       = 0;

  // Register byte offsets
  localparam logic [11:0] OFS_STATUS  = 12'h000;  // Sticky fault events, read clears
  localparam logic [11:0] OFS_MASK    = 12'h004;  // Interrupt mask, same layout
  localparam logic [11:0] OFS_LIVE    = 12'h008;  // Filtered faults and logic levels
  localparam logic [11:0] OFS_RAW     = 12'h00C;  // Comparator states before filter
  localparam logic [11:0] OFS_CH_BASE = 12'h040;  // Per channel: threshold word, control
  localparam logic [11:0] CH_STRIDE   = 12'h008;

  // Threshold word fields
  localparam int unsigned UV_LSB   = 0;
  localparam int unsigned OV_LSB   = 8;
  localparam int unsigned HYST_LSB = 16;
  localparam int unsigned HYST_W   = 5;
  localparam logic [31:0] THR_WMASK = 32'h001F_FFFF;
  localparam logic [31:0] THR_RESET = 32'h0000_0000;

  // Control word fields
  localparam int unsigned MODE_LSB  = 0;
  localparam int unsigned RANGE_LSB = 2;
  localparam int unsigned EN_BIT    = 4;
  localparam int unsigned LSEL_BIT  = 5;
  localparam int unsigned GLT_LSB   = 8;
  localparam int unsigned GLT_W     = 7;
  localparam logic [31:0] CTL_WMASK = 32'h0000_7F3F;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // Fault type, Gray coded
  typedef enum logic [1:0] {
    SUPFLT_UNDER  = 2'h0,
    SUPFLT_OVER   = 2'h1,
    SUPFLT_WINDOW = 2'h3
  } supflt_mode_t;

  // Input ranges: 0 lowest (0.573 V + 0.802 V span) .. 3 highest (6.0 V + 8.4 V)
  localparam logic [1:0] RANGE_LOW  = 2'h0;
  localparam logic [1:0] RANGE_MID  = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;
  localparam logic [1:0] RANGE_TOP  = 2'h3;

  // Timebase for glitch filter: one microsecond tick
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  GLITCH_MAX_US = 7'h64;  // 100 us

endpackage : supflt_pkg

// File: hw/supflt_glitch_filter.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Glitch filter: a new input level must hold for the timeout before it shows
// ---------------------------------------------------------------------------
module supflt_glitch_filter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,     // One microsecond enable pulse
  input  wire logic [6:0] timeout,  // Timeout in microseconds
  input  wire logic       din,      // Comparator state after hysteresis, or the logic pin in logic mode
  output logic            dout      // Filtered state
);

  logic [6:0] cnt_q;   // Ticks the new level has held
  logic [6:0] cnt_d;
  logic       dout_q;
  logic       dout_d;

  // Next state: count ticks while input differs, restart on any return
  always_comb begin
    cnt_d  = cnt_q;
    dout_d = dout_q;
    if (din == dout_q) begin
      cnt_d = 7'h00;                          // Short pulse gone, suppressed
    end else if (timeout == 7'h00) begin
      dout_d = din;                           // No filtering wanted
    end else if (tick) begin
      if (cnt_q + 7'h01 >= timeout) begin
        dout_d = din;                         // Held for the whole timeout
        cnt_d  = 7'h00;
      end else begin
        cnt_d = cnt_q + 7'h01;                // Duration measured on timebase
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 7'h00;
      dout_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      dout_q <= dout_d;
    end
  end

  assign dout = dout_q;

endmodule : supflt_glitch_filter

// File: tb/supflt_rails.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Monitored rails: digitised levels and dual-channel logic pins
// ---------------------------------------------------------------------------
module supflt_rails (
  output logic      [79:0] level_code,  // Eight bits per channel
  output logic      [4:0]  logic_in     // Dual pins used as logic
);
  // Rails start at ground, channels are disabled at reset anyway
  initial begin
    level_code = 80'h0;
    logic_in   = 5'h0;
  end
  // Non-blocking so a change made at an edge lands after that edge
  task automatic set_lvl(input int ch, input logic [7:0] v);
    level_code[8*ch +: 8] <= v;
  endtask : set_lvl
  task automatic set_lg(input int j, input logic v);
    logic_in[j] <= v;
  endtask : set_lg
endmodule : supflt_rails

// File: tb/supflt_detector_asserts.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------------------
module supflt_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [9:0]  fault_out,
  input wire logic [4:0]  logic_out,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One wait state, then a single-cycle answer
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_cause_a: assert property (pready |-> $past(psel && penable && !pready))
    else $error("pready without access");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  err_cause_a: assert property (pslverr |-> $past(psel && penable))
    else $error("pslverr without access");
  misalign_err_a: assert property (psel && penable && !pready && paddr[1:0] != 2'h0
    |=> pslverr) else $error("misaligned access accepted");
  // Read data only moves on a read
  prdata_hold_a: assert property (!(psel && penable && !pready && !pwrite)
    |=> $stable(prdata)) else $error("prdata moved");
  dual_excl_a: assert property ((fault_out[9:5] & logic_out) == 5'h00)
    else $error("dual channel in both roles");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($rose(fault_out[0]));
  cover property ($rose(logic_out[1]));
endmodule : supflt_chk
bind supflt_detector supflt_chk supflt_chk_i (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .fault_out, .logic_out, .irq);

// File: tb/tb_top.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Testbench top
// ---------------------------------------------------------------------------
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [79:0] level_code;
  logic [4:0]  logic_in, logic_out;
  logic [9:0]  fault_out;
  logic [14:0] obs;           // Faults in 0..9, logic levels in 10..14
  logic        er;
  int          num_errors, total_checks, n;
  assign obs = {logic_out, fault_out};
  supflt_detector supflt_detector_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .level_code, .logic_in, .fault_out,
    .logic_out, .irq);
  supflt_rails supflt_rails_i (.level_code, .logic_in);
  // Clock: 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int   k;
    logic seen;   // Answer arrived before the bound ran out
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    seen = (pready === 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (!seen) begin
      num_errors++;
      final_report;
    end
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rdchk
  function automatic logic [11:0] ca(input int i);
    return 12'(supflt_pkg::OFS_CH_BASE + supflt_pkg::CH_STRIDE * i);
  endfunction : ca
  // Bounded wait for an output level; n holds the cycles taken
  task automatic wait_f(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v && n <= lim) begin
      @(posedge pclk);
      n++;
    end
    chk(obs[b], v);
    if (n > lim) final_report;
  endtask : wait_f
  task automatic hold_f(input int b, input logic v, input int c);
    logic ok;
    ok = 1'b1;
    repeat (c) begin
      @(posedge pclk);
      if (obs[b] !== v) ok = 1'b0;
    end
    chk(ok, 1'b1);
  endtask : hold_f
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    rdchk(ca(1), 32'h0000_0000);
    apb(ca(1), 1'b1, 32'hFFFF_FFFF);
    rdchk(ca(1), 32'h001F_FFFF);
    // Only byte lane 1 written: the overvoltage code alone
    pstrb <= 4'h2;
    apb(ca(2), 1'b1, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    rdchk(ca(2), 32'h0000_FF00);
    apb(12'h0F0, 1'b0, 32'h0);
    chk(er, 1'b1);
    apb(12'h002, 1'b0, 32'h0);
    chk(er, 1'b1);
    apb(ca(0) + 12'h4, 1'b1, 32'h0000_7F19);
    rdchk(ca(0) + 12'h4, 32'h0000_6419);
    apb(ca(0) + 12'h4, 1'b1, 32'h0000_0011);
    rdchk(ca(0) + 12'h4, 32'h0000_0019);
    apb(ca(5) + 12'h4, 1'b1, 32'h0000_000C);
    rdchk(ca(5) + 12'h4, 32'h0000_0000);
    apb(ca(1) + 12'h4, 1'b1, 32'h0000_0020);
    rdchk(ca(1) + 12'h4, 32'h0000_0000);
  endtask : t_regs
  // Channel 1 undervoltage, uv 100, hysteresis 5, no filter delay
  task automatic t_under;
    supflt_rails_i.set_lvl(1, 8'h96);
    apb(ca(1), 1'b1, 32'h0005_C864);
    apb(ca(1) + 12'h4, 1'b1, 32'h0000_0014);
    apb(supflt_pkg::OFS_MASK, 1'b1, 32'h0000_0002);
    apb(supflt_pkg::OFS_STATUS, 1'b0, 32'h0);
    supflt_rails_i.set_lvl(1, 8'h64);
    hold_f(1, 1'b0, 20);
    supflt_rails_i.set_lvl(1, 8'h63);
    wait_f(1, 1'b1, 6);
    chk(n <= 5, 1'b1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    rdchk(supflt_pkg::OFS_STATUS, 32'h0000_0002);
    rdchk(supflt_pkg::OFS_STATUS, 32'h0000_0000);
    chk(irq, 1'b0);
    supflt_rails_i.set_lvl(1, 8'h69);
    hold_f(1, 1'b1, 20);
    supflt_rails_i.set_lvl(1, 8'h6A);
    wait_f(1, 1'b0, 6);
    // Masked event still sets the sticky bit but raises no interrupt
    apb(supflt_pkg::OFS_MASK, 1'b1, 32'h0000_0000);
    supflt_rails_i.set_lvl(1, 8'h5A);
    wait_f(1, 1'b1, 6);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    rdchk(supflt_pkg::OFS_STATUS, 32'h0000_0002);
  endtask : t_under
  // Channel 0 overvoltage at 50 with a 3 us filter
  task automatic t_over;
    // Threshold first: the channel is live, a rail above 0 would trip it
    apb(ca(0), 1'b1, 32'h0000_3200);
    supflt_rails_i.set_lvl(0, 8'h28);
    apb(ca(0) + 12'h4, 1'b1, 32'h0000_0319);
    hold_f(0, 1'b0, 400);
    supflt_rails_i.set_lvl(0, 8'h3C);
    repeat (200) @(posedge pclk);
    supflt_rails_i.set_lvl(0, 8'h28);
    hold_f(0, 1'b0, 700);
    supflt_rails_i.set_lvl(0, 8'h3C);
    wait_f(0, 1'b1, 600);
    chk(n >= 250 && n <= 390, 1'b1);
    supflt_rails_i.set_lvl(0, 8'h28);
    wait_f(0, 1'b0, 600);
    chk(n >= 250 && n <= 390, 1'b1);
  endtask : t_over
  // Channel 5 window 50..150, walked out low and high
  task automatic t_window;
    logic [7:0] lv [4] = '{8'hA0, 8'h64, 8'h28, 8'h64};
    supflt_rails_i.set_lvl(5, 8'h64);
    apb(ca(5), 1'b1, 32'h0000_9632);
    apb(ca(5) + 12'h4, 1'b1, 32'h0000_0013);
    hold_f(5, 1'b0, 20);
    for (int i = 0; i < 4; i++) begin
      supflt_rails_i.set_lvl(5, lv[i]);
      wait_f(5, ~i[0], 6);
    end
  endtask : t_window
  // Channel 6 as logic input: detector stays silent though below uv
  task automatic t_logic;
    apb(ca(6), 1'b1, 32'h0000_00C8);
    apb(ca(6) + 12'h4, 1'b1, 32'h0000_0030);
    supflt_rails_i.set_lg(1, 1'b1);
    wait_f(11, 1'b1, 8);
    // Live: logic level of channel 6, fault of channel 1 still standing
    rdchk(supflt_pkg::OFS_LIVE, 32'h0002_0002);
    // Raw: comparator of channel 6 idle though its rail is below threshold
    rdchk(supflt_pkg::OFS_RAW, 32'h0000_0842);
    hold_f(6, 1'b0, 20);
    supflt_rails_i.set_lg(1, 1'b0);
    wait_f(11, 1'b0, 8);
  endtask : t_logic
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_under;
    t_over;
    t_window;
    t_logic;
    final_report;
  end
endmodule : tb_top
